// ### core/pdl_pkg.sv
/*
 Shared constants, register map and state types of the delimiter and link block.
 Assumes a single 250 MHz system clock and symbol-aligned 5B code groups.
*/
package pdl_pkg;
	// ---------------------------------------------------------------
	// Clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ       = 250;
	localparam int BREAK_MS      = 1200;
	localparam int NLP_MS        = 16;
	localparam int LINK_FAIL_MS  = 50;
	localparam int FLP_GAP_NS    = 62500;
	localparam int SQ_WIN_NS     = 250;
	localparam int SOI_GAP_NS    = 200;
	localparam int SOI_TX_NS     = 250;
	localparam int BREAK_CYC     = BREAK_MS * CLK_MHZ * 1000;
	localparam int NLP_CYC       = NLP_MS * CLK_MHZ * 1000;
	localparam int LINK_FAIL_CYC = LINK_FAIL_MS * CLK_MHZ * 1000;
	localparam int FLP_GAP_CYC   = FLP_GAP_NS * CLK_MHZ / 1000;
	localparam int SQ_WIN_CYC    = SQ_WIN_NS * CLK_MHZ / 1000;
	localparam int SOI_GAP_CYC   = (SOI_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int SOI_TX_CYC    = (SOI_TX_NS * CLK_MHZ + 999) / 1000;

	// ---------------------------------------------------------------
	// Code groups
	// ---------------------------------------------------------------
	localparam logic [4:0] SYM_I = 5'h1f;
	localparam logic [4:0] SYM_J = 5'h18;
	localparam logic [4:0] SYM_K = 5'h11;
	localparam logic [4:0] SYM_T = 5'h0d;
	localparam logic [4:0] SYM_R = 5'h07;
	localparam logic [4:0] SYM_5 = 5'h0b;
	localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	localparam logic [3:0]  ADDR_CTRL  = 4'h0;
	localparam logic [3:0]  ADDR_ADV   = 4'h4;
	localparam logic [3:0]  ADDR_REM   = 4'h8;
	localparam logic [3:0]  ADDR_STAT  = 4'hc;
	localparam int          CTRL_ANEG  = 0;
	localparam int          CTRL_RST   = 1;
	localparam int          CTRL_SPD   = 2;
	localparam int          CTRL_DPX   = 3;
	localparam int          ST_BADSSD  = 0;
	localparam int          ST_BADESD  = 1;
	localparam int          ST_LINK    = 2;
	localparam int          ST_SPDDET  = 3;
	localparam int          ST_DPXDET  = 4;
	localparam int          ST_ANDONE  = 5;
	localparam int          ADV_10HD   = 5;
	localparam int          ADV_10FD   = 6;
	localparam int          ADV_100HD  = 7;
	localparam int          ADV_100FD  = 8;
	localparam int          ADV_ACK    = 14;
	localparam logic [15:0] ADV_RESET  = 16'h01e1;

	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_PRE = 2'b01, TX_DATA = 2'b10, TX_END = 2'b11} pdl_tx_t;
	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_DATA = 2'b01, RX_FALSE = 2'b10} pdl_rx_t;
	typedef enum logic [2:0] {AN_OFF = 3'b000, AN_BREAK = 3'b001, AN_DETECT = 3'b010,
		AN_ACK = 3'b011, AN_DONE = 3'b100} pdl_an_t;
endpackage

// ### core/pdl_flp_tx.sv
/*
 Fast link pulse burst sender: 17 clock pulses interleaved with 16 data pulses.
 Assumes start is a one-cycle pulse; a start during a burst is ignored.
*/
`timescale 1ns/1ps
`default_nettype none
module pdl_flp_tx #(
	parameter int GAP = pdl_pkg::FLP_GAP_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic [15:0] word,
	output logic             pulse,
	output logic             busy
);
	typedef struct packed {
		logic        busy;
		logic [5:0]  slot;
		logic [31:0] cnt;
		logic        pulse;
		logic [15:0] word;
	} pdl_flp_st_t;

	pdl_flp_st_t r;
	pdl_flp_st_t next_r;

	always_comb begin
		next_r = r;
		next_r.pulse = 1'b0;
		if (!r.busy && start) begin
			next_r = '{busy: 1'b1, slot: 6'd0, cnt: 32'd0, pulse: 1'b0, word: word};
		end else if (r.busy) begin
			next_r.cnt = r.cnt + 32'd1;
			if (r.cnt == 32'(GAP - 1)) begin
				next_r.cnt = 32'd0;
				// Even slots are clock pulses; odd slots carry bit D0 first.
				next_r.pulse = r.slot[0] ? r.word[r.slot[4:1]] : 1'b1;
				next_r.slot = r.slot + 6'd1;
				if (r.slot == 6'd32) begin
					next_r.busy = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign pulse = r.pulse;
	assign busy  = r.busy;
endmodule
`default_nettype wire

// ### core/pdl_squelch.sv
/*
 10 Mbps squelch and start-of-idle detector producing the carrier level.
 Assumes crossing and zero-crossing inputs are one-cycle pulses in this clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pdl_squelch #(
	parameter int WIN = pdl_pkg::SQ_WIN_CYC,
	parameter int GAP = pdl_pkg::SOI_GAP_CYC
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic sqPos,
	input  wire logic sqNeg,
	input  wire logic zeroX,
	output logic      crs,
	output logic      soi
);
	typedef struct packed {
		logic [1:0] cnt;
		logic       pol;
		logic [7:0] win;
		logic       crs;
		logic [7:0] idle;
		logic       soi;
	} pdl_sq_st_t;

	pdl_sq_st_t r;
	pdl_sq_st_t next_r;

	always_comb begin
		next_r = r;
		next_r.soi = 1'b0;
		if (!r.crs) begin
			if (r.cnt != 2'd0) begin
				next_r.win = r.win + 8'd1;
			end
			if (r.win > 8'(WIN)) begin
				next_r.cnt = 2'd0;
			end
			if (sqPos || sqNeg) begin
				next_r.pol = sqPos;
				if (r.cnt != 2'd0 && r.pol != sqPos && r.win <= 8'(WIN)) begin
					next_r.cnt = r.cnt + 2'd1;
					if (r.cnt == 2'd2) begin
						next_r.crs  = 1'b1;
						next_r.cnt  = 2'd0;
						next_r.idle = 8'd0;
					end
				end else begin
					next_r.cnt = 2'd1;
					next_r.win = 8'd0;
				end
			end
		end else begin
			next_r.idle = zeroX ? 8'd0 : r.idle + 8'd1;
			if (r.idle >= 8'(GAP - 1)) begin
				next_r.crs = 1'b0;
				next_r.soi = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign crs = r.crs;
	assign soi = r.soi;
endmodule
`default_nettype wire

// ### core/pdl_delim_link.sv
/*
 Delimiter coding, 10 Mbps framing, link integrity and auto-negotiation of the PHY.
 Assumes symbol strobes mark aligned 5B groups and partner words arrive decoded.
*/
// Overview of operation
// - 100M transmit puts J then K in place of the first two preamble symbols.
// - Receiver in idle reports no valid data to the MAC.
// - J-K pair in idle starts reception, data valid, two /5/ symbols out.
// - Other noisy pair in idle raises false carrier, error and bad start flag.
// - After false carrier, start pairs are ignored until an idle pair.
// - Other quiet pairs in idle are dropped; receiver stays idle.
// - 10M start of packet is squelch valid data; carrier sense asserts.
// - 100M transmit appends T then R right after the last data symbol.
// - T-R pair during reception ends it and is replaced by idle symbols.
// - Idle pair during reception flags error on first idle, sets bad end flag.
// - 10M transmit appends a start-of-idle pulse after transmit enable drops.
// - 10M start-of-idle from missing transitions ends reception.
// - Link logic runs either standard link integrity or auto-negotiation.
// - 10M link pass by normal link pulses; pulses sent while idle.
// - 100M link pass from squelch and descrambler lock, no pulses.
// - Negotiation trades 16-bit words in fast link pulse bursts.
// - Negotiation starts on enable, on link fail or on restart request.
// - Plain 10M or 100M partner signal selects that mode directly.
// - Bursts carry the advertisement; partner word lands in remote register.
// - On completion resolve speed and duplex by priority and apply them.
// - Resolved speed and duplex show in their status bits.
// - On enable all transmission stops for the break time, then negotiation.
// - 10M valid data needs three alternating crossings inside the window.
`timescale 1ns/1ps
`default_nettype none
module pdl_delim_link #(
	parameter int BREAK_CYC = pdl_pkg::BREAK_CYC,
	parameter int NLP_CYC   = pdl_pkg::NLP_CYC,
	parameter int FAIL_CYC  = pdl_pkg::LINK_FAIL_CYC,
	parameter int FLP_GAP   = pdl_pkg::FLP_GAP_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wrData,
	input  wire logic        wrStb,
	input  wire logic        rdStb,
	output logic      [15:0] rdData,
	input  wire logic        txEn,
	input  wire logic [3:0]  txData,
	input  wire logic        txSymStb,
	output logic      [4:0]  txCode,
	output logic             txLineEn,
	output logic             soiPulse,
	output logic             linkPulse,
	input  wire logic        rxSymStb,
	input  wire logic [4:0]  rxCode,
	output logic      [4:0]  rxCodeOut,
	output logic             rxDv,
	output logic             rxEr,
	output logic             rxFalse,
	output logic             crs,
	input  wire logic        sqPos,
	input  wire logic        sqNeg,
	input  wire logic        zeroX,
	input  wire logic        sig100,
	input  wire logic        descLock,
	input  wire logic        rxNlp,
	input  wire logic        rxFlpValid,
	input  wire logic [15:0] rxFlpWord,
	output logic             linkPass,
	output logic             speed100,
	output logic             fullDuplex
);
	typedef struct packed {
		pdl_pkg::pdl_tx_t txSt;
		logic [4:0]       txCode;
		logic             txEnPrev;
		logic [7:0]       soiCnt;
		logic             soiPulse;
		pdl_pkg::pdl_rx_t rxSt;
		logic [4:0]       prevCode;
		logic             substNext;
		logic [4:0]       substCode;
		logic [4:0]       rxCodeOut;
		logic             rxDv;
		logic             rxEr;
		logic             rxFalse;
		logic             crs;
		logic             badSsd;
		logic             badEsd;
		logic             anegEn;
		logic             anegEnPrev;
		logic             speedSel;
		logic             duplexSel;
		logic [15:0]      adv;
		logic [15:0]      remote;
		logic [15:0]      rdData;
		pdl_pkg::pdl_an_t anSt;
		logic [31:0]      anTimer;
		logic [31:0]      linkTimer;
		logic             resSpeed;
		logic             resDuplex;
		logic             linkPass;
		logic             linkPulse;
		logic             txLineEn;
		logic             flpStart;
		logic [15:0]      flpWord;
		logic             speed100;
		logic             fullDuplex;
	} pdl_top_st_t;

	pdl_top_st_t r;
	pdl_top_st_t next_r;
	logic        crs10;
	logic        soiSeen;
	logic        flpPulse;
	logic        flpBusy;
	logic [9:0]  pair;
	logic        isJK;
	logic        isTR;
	logic        isII;
	logic        sp100;
	logic        dpx;
	logic        linkOk;
	logic        startAn;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Two separate runs of zeros mean real activity; a lone J with idle is one run.
	function automatic logic twoZeroRuns(input logic [9:0] v);
		logic [10:0] w;
		logic [3:0]  runs;
		w = {1'b1, v};
		runs = 4'd0;
		for (int i = 0; i < 10; i++) begin
			if (!w[i] && w[i+1]) begin
				runs = runs + 4'd1;
			end
		end
		return runs >= 4'd2;
	endfunction

	pdl_squelch u_squelch (
		.clk_sys (clk_sys),
		.rst     (rst),
		.sqPos   (sqPos),
		.sqNeg   (sqNeg),
		.zeroX   (zeroX),
		.crs     (crs10),
		.soi     (soiSeen)
	);

	pdl_flp_tx #(.GAP(FLP_GAP)) u_flp (
		.clk_sys (clk_sys),
		.rst     (rst),
		.start   (r.flpStart),
		.word    (r.flpWord),
		.pulse   (flpPulse),
		.busy    (flpBusy)
	);

	assign pair  = {r.prevCode, rxCode};
	assign isJK  = pair == {pdl_pkg::SYM_J, pdl_pkg::SYM_K};
	assign isTR  = pair == {pdl_pkg::SYM_T, pdl_pkg::SYM_R};
	assign isII  = pair == {pdl_pkg::SYM_I, pdl_pkg::SYM_I};
	assign sp100 = r.anegEn ? r.resSpeed : r.speedSel;
	assign dpx   = r.anegEn ? r.resDuplex : r.duplexSel;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.rdData = 16'h0000;
		next_r.flpStart = 1'b0;
		next_r.linkPulse = 1'b0;
		next_r.txEnPrev = txEn;
		next_r.anegEnPrev = r.anegEn;
		linkOk = 1'b0;
		startAn = 1'b0;

		if (rdStb) begin
			unique case (addr)
				pdl_pkg::ADDR_CTRL: next_r.rdData = {12'h000, r.duplexSel, r.speedSel, 1'b0, r.anegEn};
				pdl_pkg::ADDR_ADV:  next_r.rdData = r.adv;
				pdl_pkg::ADDR_REM:  next_r.rdData = r.remote;
				pdl_pkg::ADDR_STAT: begin
					next_r.rdData[pdl_pkg::ST_BADSSD] = r.badSsd;
					next_r.rdData[pdl_pkg::ST_BADESD] = r.badEsd;
					next_r.rdData[pdl_pkg::ST_LINK]   = r.linkPass;
					next_r.rdData[pdl_pkg::ST_SPDDET] = r.resSpeed;
					next_r.rdData[pdl_pkg::ST_DPXDET] = r.resDuplex;
					next_r.rdData[pdl_pkg::ST_ANDONE] = r.anSt == pdl_pkg::AN_DONE;
					next_r.badSsd = 1'b0;
					next_r.badEsd = 1'b0;
				end
				default: next_r.rdData = 16'h0000;
			endcase
		end
		if (wrStb && addr == pdl_pkg::ADDR_CTRL) begin
			next_r.anegEn    = wrData[pdl_pkg::CTRL_ANEG];
			next_r.speedSel  = wrData[pdl_pkg::CTRL_SPD];
			next_r.duplexSel = wrData[pdl_pkg::CTRL_DPX];
			startAn = wrData[pdl_pkg::CTRL_ANEG] && wrData[pdl_pkg::CTRL_RST];
		end
		if (wrStb && addr == pdl_pkg::ADDR_ADV) begin
			next_r.adv = wrData;
		end

		// Transmit encoder, one code group per symbol strobe.
		if (txSymStb) begin
			unique case (r.txSt)
				pdl_pkg::TX_IDLE: begin
					next_r.txCode = pdl_pkg::SYM_I;
					if (txEn) begin
						next_r.txCode = pdl_pkg::SYM_J;
						next_r.txSt = pdl_pkg::TX_PRE;
					end
				end
				pdl_pkg::TX_PRE: begin
					next_r.txCode = pdl_pkg::SYM_K;
					next_r.txSt = pdl_pkg::TX_DATA;
				end
				pdl_pkg::TX_DATA: begin
					next_r.txCode = pdl_pkg::ENC[txData];
					if (!txEn) begin
						next_r.txCode = pdl_pkg::SYM_T;
						next_r.txSt = pdl_pkg::TX_END;
					end
				end
				pdl_pkg::TX_END: begin
					next_r.txCode = pdl_pkg::SYM_R;
					next_r.txSt = pdl_pkg::TX_IDLE;
				end
			endcase
		end
		next_r.soiCnt = (r.soiCnt != 8'd0) ? r.soiCnt - 8'd1 : 8'd0;
		if (!sp100 && r.txEnPrev && !txEn) begin
			next_r.soiCnt = 8'(pdl_pkg::SOI_TX_CYC);
		end
		next_r.soiPulse = next_r.soiCnt != 8'd0;

		// Receive delimiter detector.
		if (!sp100) begin
			next_r.rxSt = pdl_pkg::RX_IDLE;
			next_r.rxDv = crs10 && !soiSeen;
			next_r.rxEr = 1'b0;
			next_r.rxFalse = 1'b0;
		end else if (rxSymStb) begin
			next_r.prevCode = rxCode;
			next_r.substNext = 1'b0;
			next_r.rxCodeOut = r.substNext ? r.substCode : r.prevCode;
			unique case (r.rxSt)
				pdl_pkg::RX_IDLE: begin
					next_r.rxDv = 1'b0;
					next_r.rxEr = 1'b0;
					next_r.rxFalse = 1'b0;
					if (isJK) begin
						next_r.rxSt = pdl_pkg::RX_DATA;
						next_r.rxDv = 1'b1;
						next_r.rxCodeOut = pdl_pkg::SYM_5;
						next_r.substNext = 1'b1;
						next_r.substCode = pdl_pkg::SYM_5;
					end else if (!isII && twoZeroRuns(pair)) begin
						next_r.rxSt = pdl_pkg::RX_FALSE;
						next_r.rxFalse = 1'b1;
						next_r.rxEr = 1'b1;
						next_r.badSsd = 1'b1;
					end
				end
				pdl_pkg::RX_DATA: begin
					next_r.rxEr = 1'b0;
					if (isTR) begin
						next_r.rxSt = pdl_pkg::RX_IDLE;
						next_r.rxDv = 1'b0;
						next_r.rxCodeOut = pdl_pkg::SYM_I;
						next_r.substNext = 1'b1;
						next_r.substCode = pdl_pkg::SYM_I;
					end else if (isII) begin
						next_r.rxSt = pdl_pkg::RX_IDLE;
						next_r.rxEr = 1'b1;
						next_r.badEsd = 1'b1;
					end
				end
				pdl_pkg::RX_FALSE: begin
					if (isII) begin
						next_r.rxSt = pdl_pkg::RX_IDLE;
						next_r.rxFalse = 1'b0;
						next_r.rxEr = 1'b0;
					end
				end
				default: next_r.rxSt = pdl_pkg::RX_IDLE;
			endcase
		end
		next_r.crs = sp100 ? (next_r.rxDv || next_r.rxFalse) : crs10;

		// Link integrity for the active speed.
		if (sp100) begin
			linkOk = sig100 && descLock;
			next_r.linkPass = linkOk;
		end else begin
			next_r.linkTimer = r.linkTimer + 32'd1;
			linkOk = r.linkTimer < 32'(FAIL_CYC - 1);
			if (rxNlp || crs10) begin
				next_r.linkTimer = 32'd0;
				linkOk = 1'b1;
			end
			next_r.linkPass = linkOk;
		end

		// Negotiation sequencer.
		if (r.anegEn && !r.anegEnPrev) begin
			startAn = 1'b1;
		end
		next_r.anTimer = r.anTimer + 32'd1;
		unique case (r.anSt)
			pdl_pkg::AN_OFF, pdl_pkg::AN_DONE: begin
				if (!sp100 && !txEn && r.anTimer >= 32'(NLP_CYC - 1)) begin
					next_r.anTimer = 32'd0;
					next_r.linkPulse = 1'b1;
				end
				if (r.anSt == pdl_pkg::AN_DONE && r.linkPass && !linkOk) begin
					startAn = 1'b1;
				end
			end
			pdl_pkg::AN_BREAK: begin
				next_r.linkPass = 1'b0;
				if (r.anTimer == 32'(BREAK_CYC - 1)) begin
					next_r.anSt = pdl_pkg::AN_DETECT;
					next_r.anTimer = 32'd0;
				end
			end
			pdl_pkg::AN_DETECT, pdl_pkg::AN_ACK: begin
				next_r.linkPass = 1'b0;
				next_r.linkPulse = flpPulse;
				if (r.anTimer >= 32'(NLP_CYC - 1)) begin
					next_r.anTimer = 32'd0;
				end
				next_r.flpStart = r.anTimer == 32'd0 && !flpBusy;
				next_r.flpWord = r.adv;
				next_r.flpWord[pdl_pkg::ADV_ACK] = r.anSt == pdl_pkg::AN_ACK;
				if (rxFlpValid) begin
					next_r.remote = rxFlpWord;
					next_r.anSt = pdl_pkg::AN_ACK;
					if (r.anSt == pdl_pkg::AN_ACK && rxFlpWord[pdl_pkg::ADV_ACK]) begin
						next_r.anSt = pdl_pkg::AN_DONE;
						next_r.resSpeed = (r.adv[pdl_pkg::ADV_100FD] && rxFlpWord[pdl_pkg::ADV_100FD])
							|| (r.adv[pdl_pkg::ADV_100HD] && rxFlpWord[pdl_pkg::ADV_100HD]);
						next_r.resDuplex = (r.adv[pdl_pkg::ADV_100FD] && rxFlpWord[pdl_pkg::ADV_100FD])
							|| (!next_r.resSpeed && r.adv[pdl_pkg::ADV_10FD] && rxFlpWord[pdl_pkg::ADV_10FD]);
					end
				end else if (r.anSt == pdl_pkg::AN_DETECT && rxNlp) begin
					next_r.anSt = pdl_pkg::AN_DONE;
					next_r.resSpeed = 1'b0;
					next_r.resDuplex = 1'b0;
				end else if (r.anSt == pdl_pkg::AN_DETECT && sig100 && descLock) begin
					next_r.anSt = pdl_pkg::AN_DONE;
					next_r.resSpeed = 1'b1;
					next_r.resDuplex = 1'b0;
				end
			end
			default: next_r.anSt = pdl_pkg::AN_OFF;
		endcase
		if (startAn) begin
			next_r.anSt = pdl_pkg::AN_BREAK;
			next_r.anTimer = 32'd0;
			next_r.linkPulse = 1'b0;
		end
		if (!next_r.anegEn) begin
			next_r.anSt = (r.anSt == pdl_pkg::AN_OFF) ? pdl_pkg::AN_OFF : pdl_pkg::AN_OFF;
		end
		next_r.txLineEn = next_r.anSt != pdl_pkg::AN_BREAK;
		next_r.speed100 = sp100;
		next_r.fullDuplex = dpx;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r <= '0;
			r.adv <= pdl_pkg::ADV_RESET;
			r.txCode <= pdl_pkg::SYM_I;
			r.prevCode <= pdl_pkg::SYM_I;
			r.rxCodeOut <= pdl_pkg::SYM_I;
			r.txLineEn <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign rdData = r.rdData;
	assign txCode = r.txCode;
	assign txLineEn = r.txLineEn;
	assign soiPulse = r.soiPulse;
	assign linkPulse = r.linkPulse && r.txLineEn;
	assign rxCodeOut = r.rxCodeOut;
	assign rxDv = r.rxDv;
	assign rxEr = r.rxEr;
	assign rxFalse = r.rxFalse;
	assign crs = r.crs;
	assign linkPass = r.linkPass;
	assign speed100 = r.speed100;
	assign fullDuplex = r.fullDuplex;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_rxIdleStb;
		sp100 && rxSymStb && r.rxSt == pdl_pkg::RX_IDLE;
	endsequence
	sequence s_rxDataStb;
		sp100 && rxSymStb && r.rxSt == pdl_pkg::RX_DATA;
	endsequence

	a_ssd_subst: assert property (s_rxIdleStb and isJK
		|=> rxDv && rxCodeOut == pdl_pkg::SYM_5 && r.substNext && r.substCode == pdl_pkg::SYM_5)
		else $error("start delimiter not replaced by two five symbols");
	a_false_carrier: assert property (s_rxIdleStb and !isJK && !isII && twoZeroRuns(pair)
		|=> rxFalse && rxEr && r.badSsd && r.rxSt == pdl_pkg::RX_FALSE)
		else $error("false carrier not raised");
	a_false_hold: assert property (sp100 && rxSymStb && r.rxSt == pdl_pkg::RX_FALSE && !isII
		|=> r.rxSt == pdl_pkg::RX_FALSE && !rxDv)
		else $error("false carrier left without idle pair");
	a_quiet_drop: assert property (s_rxIdleStb and !isJK && !twoZeroRuns(pair)
		|=> r.rxSt == pdl_pkg::RX_IDLE && !rxDv && !rxFalse)
		else $error("quiet pair left idle");
	a_esd_end: assert property (s_rxDataStb and isTR |=> !rxDv && rxCodeOut == pdl_pkg::SYM_I)
		else $error("end delimiter not replaced by idle");
	a_esd_bad: assert property (s_rxDataStb and isII |=> rxEr && r.badEsd ##1 !rxFalse)
		else $error("premature end not flagged");
	a_tx_jk: assert property (txSymStb && r.txSt == pdl_pkg::TX_IDLE && txEn
		|=> txCode == pdl_pkg::SYM_J && r.txSt == pdl_pkg::TX_PRE)
		else $error("start delimiter not sent");
	a_tx_tr: assert property (txSymStb && r.txSt == pdl_pkg::TX_DATA && !txEn
		|=> txCode == pdl_pkg::SYM_T && r.txSt == pdl_pkg::TX_END)
		else $error("end delimiter not sent");
	a_tx_r: assert property (txSymStb && r.txSt == pdl_pkg::TX_END |=> txCode == pdl_pkg::SYM_R)
		else $error("second end delimiter symbol not sent");
	a_soi_send: assert property (!sp100 && $fell(txEn) |=> soiPulse [*8])
		else $error("start of idle pulse missing");
	a_break_quiet: assert property (r.anSt == pdl_pkg::AN_BREAK |=> !linkPulse)
		else $error("pulse sent during break");
	a_flag_sticky: assert property (r.badSsd && !(rdStb && addr == pdl_pkg::ADDR_STAT) |=> r.badSsd)
		else $error("bad start flag lost before read");
endmodule
`default_nettype wire

// ### tb/pdl_partner.sv
/*
 Far-side symbol source: one aligned code group every four clocks.
 Assumes the bench sets the next code between strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module pdl_partner (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [4:0] code,
	output logic            rxSymStb,
	output logic      [4:0] rxCode
);
	logic [1:0] cnt;
	// An active idle line: the code is held between strobes, never released.
	always_ff @(posedge clk_sys) begin
		cnt <= rst ? 2'h0 : cnt + 2'h1;
		rxSymStb <= !rst && cnt == 2'h3;
		rxCode <= rst ? pdl_pkg::SYM_I : (cnt == 2'h3 ? code : rxCode);
	end
endmodule
`default_nettype wire

// ### tb/pdl_delim_link_test.sv
/*
 Self-checking bench of the delimiter and link block.
 Assumes the partner model feeds the received symbols.
*/
`timescale 1ns/1ps
`default_nettype none
module pdl_delim_link_test;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wrData = 16'h0000;
	logic        wrStb = 1'b0;
	logic        rdStb = 1'b0;
	logic        txEn = 1'b0;
	logic [3:0]  txData = 4'h0;
	logic        txSymStb = 1'b0;
	logic        sqPos = 1'b0;
	logic        sqNeg = 1'b0;
	logic        sig100 = 1'b0;
	logic        descLock = 1'b0;
	logic        rxFlpValid = 1'b0;
	logic [15:0] rxFlpWord = 16'h0000;
	logic [4:0]  pcode = pdl_pkg::SYM_I;
	logic [15:0] rdData, r;
	logic [4:0]  txCode, rxCode, rxCodeOut;
	logic        rxSymStb, rxDv, rxEr, rxFalse, crs;
	logic        txLineEn, soiPulse, linkPulse, linkPass, speed100, fullDuplex;
	int          fails = 0;
	int          n_compared = 0;
	always #2 clk_sys = ~clk_sys;
	pdl_partner u_far (.clk_sys(clk_sys), .rst(rst), .code(pcode), .rxSymStb(rxSymStb), .rxCode(rxCode));
	pdl_delim_link #(.BREAK_CYC(200), .NLP_CYC(2000), .FAIL_CYC(500), .FLP_GAP(10)) u_dut (
		.clk_sys(clk_sys), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
		.rdData(rdData), .txEn(txEn), .txData(txData), .txSymStb(txSymStb), .txCode(txCode),
		.txLineEn(txLineEn), .soiPulse(soiPulse), .linkPulse(linkPulse), .rxSymStb(rxSymStb), .rxCode(rxCode),
		.rxCodeOut(rxCodeOut), .rxDv(rxDv), .rxEr(rxEr), .rxFalse(rxFalse), .crs(crs),
		.sqPos(sqPos), .sqNeg(sqNeg), .zeroX(1'b0), .sig100(sig100), .descLock(descLock), .rxNlp(1'b0),
		.rxFlpValid(rxFlpValid), .rxFlpWord(rxFlpWord), .linkPass(linkPass), .speed100(speed100),
		.fullDuplex(fullDuplex));
	task automatic results;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		addr <= a;
		wrData <= d;
		wrStb <= w;
		rdStb <= !w;
		@(posedge clk_sys);
		wrStb <= 1'b0;
		rdStb <= 1'b0;
		#1 r = rdData;
	endtask
	task automatic txs(input logic e, input logic [3:0] d, input logic [4:0] exp);
		@(posedge clk_sys);
		txEn <= e;
		txData <= d;
		txSymStb <= 1'b1;
		@(posedge clk_sys);
		txSymStb <= 1'b0;
		#1 chk(16'(txCode), 16'(exp));
	endtask
	// Waits for the partner to launch the code, then lets the block take it.
	task automatic rx(input logic [4:0] c);
		int i;
		@(posedge clk_sys);
		pcode <= c;
		for (i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			#1;
			if (rxSymStb === 1'b1) break;
		end
		if (i == 8) begin
			fails++;
			results();
		end
		@(posedge clk_sys);
		#1;
	endtask
	task automatic t_tx;
		txs(1'b1, 4'h5, pdl_pkg::SYM_J);
		txs(1'b1, 4'h5, pdl_pkg::SYM_K);
		txs(1'b1, 4'h3, pdl_pkg::ENC[3]);
		txs(1'b0, 4'h0, pdl_pkg::SYM_T);
		txs(1'b0, 4'h0, pdl_pkg::SYM_R);
		$display("t_tx done");
	endtask
	task automatic t_rx;
		rx(pdl_pkg::SYM_I);
		rx(pdl_pkg::SYM_I);
		rx(5'h1e);
		chk(16'({rxFalse, rxDv}), 16'h0000);
		rx(5'h15);
		chk(16'(rxFalse), 16'h0001);
		rx(pdl_pkg::SYM_J);
		rx(pdl_pkg::SYM_K);
		chk(16'(rxDv), 16'h0000);
		rx(pdl_pkg::SYM_I);
		rx(pdl_pkg::SYM_I);
		rx(pdl_pkg::SYM_J);
		rx(pdl_pkg::SYM_K);
		chk(16'({rxDv, rxCodeOut}), 16'({1'b1, pdl_pkg::SYM_5}));
		rx(pdl_pkg::ENC[2]);
		rx(pdl_pkg::SYM_T);
		rx(pdl_pkg::SYM_R);
		chk(16'(rxDv), 16'h0000);
		rx(pdl_pkg::SYM_I);
		rx(pdl_pkg::SYM_I);
		rx(pdl_pkg::SYM_J);
		rx(pdl_pkg::SYM_K);
		rx(pdl_pkg::SYM_I);
		rx(pdl_pkg::SYM_I);
		chk(16'({rxDv, rxEr}), 16'h0003);
		bus(1'b0, pdl_pkg::ADDR_STAT, 16'h0000);
		chk(r & 16'h0003, 16'h0003);
		bus(1'b0, pdl_pkg::ADDR_STAT, 16'h0000);
		chk(r & 16'h0003, 16'h0000);
		$display("t_rx done");
	endtask
	task automatic t_sq;
		bus(1'b1, pdl_pkg::ADDR_CTRL, 16'h0000);
		@(posedge clk_sys);
		txEn <= 1'b1;
		sqPos <= 1'b1;
		@(posedge clk_sys);
		txEn <= 1'b0;
		sqPos <= 1'b0;
		sqNeg <= 1'b1;
		@(posedge clk_sys);
		sqNeg <= 1'b0;
		sqPos <= 1'b1;
		@(posedge clk_sys);
		sqPos <= 1'b0;
		repeat (4) @(posedge clk_sys);
		#1 chk(16'({crs, soiPulse}), 16'h0003);
		repeat (60) @(posedge clk_sys);
		#1 chk(16'({crs, soiPulse}), 16'h0000);
		$display("t_sq done");
	endtask
	task automatic t_an;
		int i;
		bus(1'b1, pdl_pkg::ADDR_CTRL, 16'h0001);
		repeat (100) @(posedge clk_sys);
		#1 chk(16'({txLineEn, linkPulse}), 16'h0000);
		for (i = 0; i < 300 && linkPulse !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
		end
		chk(16'(i < 300), 16'h0001);
		if (i == 300) results();
		@(posedge clk_sys);
		rxFlpValid <= 1'b1;
		rxFlpWord <= 16'h01e1;
		@(posedge clk_sys);
		rxFlpWord <= 16'h41e1;
		@(posedge clk_sys);
		rxFlpValid <= 1'b0;
		sig100 <= 1'b1;
		descLock <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1 chk(16'({speed100, fullDuplex, linkPass}), 16'h0007);
		bus(1'b0, pdl_pkg::ADDR_STAT, 16'h0000);
		chk(r & 16'h003f, 16'h003c);
		bus(1'b0, pdl_pkg::ADDR_REM, 16'h0000);
		chk(r, 16'h41e1);
		$display("t_an done");
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		bus(1'b0, pdl_pkg::ADDR_ADV, 16'h0000);
		chk(r, pdl_pkg::ADV_RESET);
		bus(1'b0, 4'h2, 16'h0000);
		chk(r, 16'h0000);
		bus(1'b1, pdl_pkg::ADDR_CTRL, 16'h0004);
		t_tx();
		t_rx();
		t_sq();
		t_an();
		results();
	end
endmodule
`default_nettype wire
